//--- src/adb_top.sv
module adb_top (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic [31:0] hrdata,
   output logic hresp,
   input wire logic mod_clk_in,
   input wire logic ana_bit_l,
   input wire logic ana_bit_r,
   input wire logic gpio_in,
   input wire logic din_in,
   input wire logic sclk_in,
   output logic gpio_out,
   output logic gpio_oe_n,
   output logic spi_miso_out,
   output logic spi_miso_oe_n,
   output logic [31:0] asi_left,
   output logic [31:0] asi_right,
   output logic asi_valid,
   output logic ana_pd_l,
   output logic ana_pd_r
);
   import adb_pkg::*;

   function automatic logic [3:0] adb_lg2(input logic [7:0] v);
      logic [3:0] r;
      r = 4'h8;
      for (int i = 0; i < 8; i++) begin
         if (v[i]) r = 4'(i);
      end
      return r;
   endfunction

   function automatic logic [31:0] adb_round(input logic [31:0] w,
                                             input logic [1:0] wl);
      logic [4:0] drop;
      logic [31:0] m;
      logic [32:0] s;
      drop = (wl == WL_16) ? DROP_16 : (wl == WL_20) ? DROP_20 :
             (wl == WL_24) ? DROP_24 : 5'h00;
      m = 32'hFFFF_FFFF << drop;
      s = {w[31], w} + ((33'h0_0000_0001 << drop) >> 1);
      if (drop == 5'h00) adb_round = w;
      else if (!w[31] && s[31]) adb_round = 32'h7FFF_FFFF & m;
      else adb_round = s[31:0] & m;
   endfunction

   // bus slave: one wait state on reads so a read right
   // after a write sees the new value
   logic rd_pend_q, wr_pend_q, hit_q, hready_q, hresp_q;
   logic [6:0] idx_q;
   logic [31:0] hrdata_q, rdata;
   logic [3:0] gpio_fn_q, spi_fn_q;
   logic [7:0] phase_q, dc_lat_q;
   logic [4:0] dc_len_q;
   logic [2:0] dc_ctl_q;
   logic [31:0] cfg_q;

   wire take = hsel & htrans[1] & hready;
   wire a_hit = (haddr[31:IDX_MSB+1] == '0);
   wire wr_go = wr_pend_q & hit_q;
   wire wr_gpio = wr_go & (idx_q == IDX_GPIO_FN);
   wire wr_spi = wr_go & (idx_q == IDX_SPI_FN);
   wire wr_ph = wr_go & (idx_q == IDX_PHASE);
   wire wr_len = wr_go & (idx_q == IDX_DC_LEN);
   wire wr_ctl = wr_go & (idx_q == IDX_DC_CTL);
   wire wr_lat = wr_go & (idx_q == IDX_DC_LAT);
   wire wr_cfg = wr_go & (idx_q == IDX_CFG);
   wire [1:0] lat_ev = {wr_lat & hwdata[LAT_R], wr_lat & hwdata[LAT_L]};

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         rd_pend_q <= 1'b0;
         wr_pend_q <= 1'b0;
         hit_q <= 1'b0;
         idx_q <= '0;
         hready_q <= 1'b1;
         hresp_q <= 1'b0;
         hrdata_q <= '0;
      end else begin
         rd_pend_q <= take & ~hwrite;
         wr_pend_q <= take & hwrite;
         hready_q <= ~(take & ~hwrite);
         hresp_q <= 1'b0;
         if (take) begin
            idx_q <= haddr[IDX_MSB:IDX_LSB];
            hit_q <= a_hit;
         end
         if (rd_pend_q) hrdata_q <= rdata;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         gpio_fn_q <= '0;
         spi_fn_q <= '0;
         phase_q <= '0;
         dc_len_q <= DC_LEN_MIN;
         dc_ctl_q <= '0;
         dc_lat_q <= '0;
         cfg_q <= CFG_RST;
      end else begin
         if (wr_gpio) gpio_fn_q <= hwdata[GPIO_FN_LSB +: 4];
         if (wr_spi) spi_fn_q <= hwdata[SPI_FN_LSB +: 4];
         if (wr_ph) phase_q <= hwdata[7:0];
         if (wr_len) dc_len_q <= hwdata[4:0];
         if (wr_ctl) dc_ctl_q <= hwdata[DC_EN_L:DC_METH];
         if (wr_lat) dc_lat_q <= hwdata[7:0];
         if (wr_cfg) cfg_q <= hwdata;
      end
   end

   wire [7:0] adc_oversampling_ratio = cfg_q[CFG_ADC_OVERSAMPLING_RATIO_LSB +: 8];
   wire [4:0] processing_block_select = cfg_q[CFG_PRB_LSB +: 5];
   wire [1:0] wl = cfg_q[CFG_WL_LSB +: 2];
   wire [1:0] dsel = cfg_q[CFG_DSEL_LSB +: 2];
   wire dmic_l = cfg_q[CFG_DMIC_L];
   wire dmic_r = cfg_q[CFG_DMIC_R];
   // no filter-type field: the processing block implies it
   adb_filt_type filt;
   assign filt = (processing_block_select >= PRB_C_FIRST) ? FILT_C :
                 (processing_block_select >= PRB_B_FIRST) ? FILT_B : FILT_A;
   // ratio check only reported; the host owns the setting
   wire cfg_ok = (filt == FILT_A && (adc_oversampling_ratio == ADC_OVERSAMPLING_RATIO_64 || adc_oversampling_ratio == ADC_OVERSAMPLING_RATIO_128))
              || (filt == FILT_B && adc_oversampling_ratio == ADC_OVERSAMPLING_RATIO_64)
              || (filt == FILT_C && adc_oversampling_ratio == ADC_OVERSAMPLING_RATIO_32);

   logic signed [23:0] rb_q [2];
   assign rdata = !hit_q ? '0 :
      (idx_q == IDX_GPIO_FN) ? 32'(gpio_fn_q) << GPIO_FN_LSB :
      (idx_q == IDX_SPI_FN) ? 32'(spi_fn_q) << SPI_FN_LSB :
      (idx_q == IDX_PHASE) ? 32'(phase_q) :
      (idx_q == IDX_DC_LEN) ? 32'(dc_len_q) :
      (idx_q == IDX_DC_CTL) ? 32'(dc_ctl_q) << DC_METH :
      (idx_q == IDX_DC_LAT) ? 32'(dc_lat_q) :
      (idx_q == IDX_DCL_H) ? 32'(rb_q[0][RES_HI +: 8]) :
      (idx_q == IDX_DCL_M) ? 32'(rb_q[0][RES_MID +: 8]) :
      (idx_q == IDX_DCL_L) ? 32'(rb_q[0][7:0]) :
      (idx_q == IDX_DCR_H) ? 32'(rb_q[1][RES_HI +: 8]) :
      (idx_q == IDX_DCR_M) ? 32'(rb_q[1][RES_MID +: 8]) :
      (idx_q == IDX_DCR_L) ? 32'(rb_q[1][7:0]) :
      (idx_q == IDX_CFG) ? cfg_q :
      (idx_q == IDX_STAT) ? 32'({cfg_ok, filt}) : '0;

   // pins: three stages, a change counts when stages two and three agree
   logic [NSYNC-1:0] s1_q, s2_q, s3_q, st_q;
   logic mod_prev_q, rise_q, fall_q;
   wire [NSYNC-1:0] raw = {ana_bit_r, ana_bit_l, sclk_in, din_in,
                           gpio_in, mod_clk_in};
   wire [NSYNC-1:0] agree = ~(s2_q ^ s3_q);
   wire [NSYNC-1:0] st_d = (agree & s3_q) | (~agree & st_q);
   wire rise = st_q[SI_MOD] & ~mod_prev_q;
   wire fall = ~st_q[SI_MOD] & mod_prev_q;

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         s1_q <= '0;
         s2_q <= '0;
         s3_q <= '0;
         st_q <= '0;
         mod_prev_q <= 1'b0;
         rise_q <= 1'b0;
         fall_q <= 1'b0;
      end else begin
         s1_q <= raw;
         s2_q <= s1_q;
         s3_q <= s2_q;
         st_q <= st_d;
         mod_prev_q <= st_q[SI_MOD];
         rise_q <= rise;
         fall_q <= fall;
      end
   end

   // microphone input and source select
   wire dm_bit = (dsel == DSEL_DIN) ? st_q[SI_DIN] :
                 (dsel == DSEL_SCLK) ? st_q[SI_SCLK] : st_q[SI_GPIO];
   wire l_src = dmic_l ? dm_bit : st_q[SI_ANL];
   wire r_src = dmic_r ? dm_bit : st_q[SI_ANR];

   // delay line sits ahead of the decimator, at modulator rate
   logic lnow_q, lold_q;
   // bits of the cycle before the edge shows; clock and data share the
   // synchroniser, so the edge arrives with the bit already changed
   logic lsrc_prev_q, rsrc_prev_q;
   logic [DLY_LAST:0] rline_q;
   wire [3:0] kshift = (filt == FILT_A) ? 4'h2 :
                       (filt == FILT_B) ? 4'h1 : 4'h0;
   wire [9:0] dprod = 10'(phase_q[6:5]) * 10'(adc_oversampling_ratio);
   wire [9:0] dscl = dprod >> kshift;
   wire [10:0] tapw = 11'(dscl) + 11'(phase_q[4:0]);
   // depth saturates at the line length for odd ratio settings
   wire [6:0] tap = (tapw > 11'(DLY_LAST)) ? DLY_LAST : tapw[6:0];
   wire ldly = phase_q[7] ? lold_q : lnow_q;
   wire rdly = rline_q[tap];

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         lnow_q <= 1'b0;
         lold_q <= 1'b0;
         rline_q <= '0;
         lsrc_prev_q <= 1'b0;
         rsrc_prev_q <= 1'b0;
      end else begin
         lsrc_prev_q <= l_src;
         rsrc_prev_q <= r_src;
         if (rise) begin
            lnow_q <= lsrc_prev_q;
            lold_q <= lnow_q;
         end
         if (fall) begin
            rline_q <= {rline_q[DLY_LAST-1:0], rsrc_prev_q};
         end
      end
   end

   // decimator: integrate and dump over one sample period
   logic [7:0] scnt_q;
   logic signed [9:0] lacc_q, racc_q;
   logic [31:0] asi_l_q, asi_r_q;
   logic asi_v_q, gpio_o_q, gpio_oe_q, spi_o_q, spi_oe_q, pdl_q, pdr_q;
   wire send = rise_q & (scnt_q == 8'(adc_oversampling_ratio - 8'h01));
   wire signed [9:0] lsum = lacc_q + (ldly ? 10'sh001 : 10'sh3FF);
   wire [4:0] sh = 5'(WORD_TOP - 5'(adb_lg2(adc_oversampling_ratio)));
   wire [31:0] lword = 32'($signed(lsum)) <<< sh;
   wire [31:0] rword = 32'($signed(racc_q)) <<< sh;

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         scnt_q <= '0;
         lacc_q <= '0;
         racc_q <= '0;
         asi_l_q <= '0;
         asi_r_q <= '0;
         asi_v_q <= 1'b0;
      end else begin
         if (rise_q) begin
            scnt_q <= send ? '0 : scnt_q + 8'h01;
            lacc_q <= send ? '0 : lsum;
         end
         if (send) racc_q <= '0;
         else if (fall_q) racc_q <= racc_q + (rdly ? 10'sh001 : 10'sh3FF);
         asi_v_q <= send;
         if (send) begin
            asi_l_q <= adb_round(lword, wl);
            asi_r_q <= adb_round(rword, wl);
         end
      end
   end

   // pins driven out and analog power-down requests
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         gpio_o_q <= 1'b0;
         gpio_oe_q <= 1'b1;
         spi_o_q <= 1'b0;
         spi_oe_q <= 1'b1;
         pdl_q <= 1'b0;
         pdr_q <= 1'b0;
      end else begin
         gpio_oe_q <= (gpio_fn_q != GPIO_FN_MODCLK);
         spi_oe_q <= (spi_fn_q != SPI_FN_MODCLK);
         gpio_o_q <= (gpio_fn_q == GPIO_FN_MODCLK) & st_q[SI_MOD];
         spi_o_q <= (spi_fn_q == SPI_FN_MODCLK) & st_q[SI_MOD];
         pdl_q <= dmic_l & cfg_q[CFG_BYP_L];
         pdr_q <= dmic_r & cfg_q[CFG_BYP_R];
      end
   end

   // dc measurement, channel 0 left on rising edges, 1 right on falling
   logic [31:0] prd_q;
   wire [4:0] rexp = dc_lat_q[4:0];
   wire prd_hit = dc_lat_q[PRST_EN] & rise_q
                  & (prd_q == ((32'h1 << rexp) - 32'h1));
   wire [4:0] dlen = (dc_len_q < DC_LEN_MIN) ? DC_LEN_MIN :
                     (dc_len_q > DC_LEN_MAX) ? DC_LEN_MAX : dc_len_q;
   wire [20:0] lenm = 21'((22'h1 << dlen) - 22'h1);
   wire [4:0] ashift = 5'(DC_FRAC - dlen);

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) prd_q <= '0;
      else if (!dc_lat_q[PRST_EN] || prd_hit) prd_q <= '0;
      else if (rise_q) prd_q <= prd_q + 32'h1;
   end

   logic signed [21:0] aacc_q [2];
   logic [20:0] acnt_q [2];
   logic signed [23:0] iir_q [2];
   logic signed [23:0] live_q [2];
   for (genvar ch = 0; ch < 2; ch++) begin : g_dc
      wire tick = (ch == 0) ? rise_q : fall_q;
      wire b = (ch == 0) ? ldly : rdly;
      wire en = dc_ctl_q[DC_EN_L - DC_METH - ch];
      wire signed [21:0] an = aacc_q[ch] + (b ? 22'sh1 : -22'sh1);
      wire signed [23:0] x = b ? DC_POS : DC_NEG;
      wire signed [24:0] df = 25'(x) - 25'(iir_q[ch]);
      wire signed [24:0] dstep = df >>> dlen;
      wire signed [23:0] inx = iir_q[ch] + 24'(dstep);
      always_ff @(posedge clk or negedge arst_n) begin
         if (!arst_n) begin
            aacc_q[ch] <= '0;
            acnt_q[ch] <= '0;
            iir_q[ch] <= '0;
            live_q[ch] <= '0;
            rb_q[ch] <= '0;
         end else begin
            if (!en || prd_hit) begin
               aacc_q[ch] <= '0;
               acnt_q[ch] <= '0;
               if (!en) iir_q[ch] <= '0;
            end else if (tick && dc_ctl_q[0]) begin
               iir_q[ch] <= inx;
               live_q[ch] <= inx;
            end else if (tick) begin
               if (acnt_q[ch] == lenm) begin
                  live_q[ch] <= 24'(an) <<< ashift;
                  aacc_q[ch] <= '0;
                  acnt_q[ch] <= '0;
               end else begin
                  aacc_q[ch] <= an;
                  acnt_q[ch] <= acnt_q[ch] + 21'h1;
               end
            end
            // readback only moves on a latch request
            if (lat_ev[ch]) rb_q[ch] <= live_q[ch];
         end
      end
   end

   assign hreadyout = hready_q;
   assign hrdata = hrdata_q;
   assign hresp = hresp_q;
   assign gpio_out = gpio_o_q;
   assign gpio_oe_n = gpio_oe_q;
   assign spi_miso_out = spi_o_q;
   assign spi_miso_oe_n = spi_oe_q;
   assign asi_left = asi_l_q;
   assign asi_right = asi_r_q;
   assign asi_valid = asi_v_q;
   assign ana_pd_l = pdl_q;
   assign ana_pd_r = pdr_q;

   default clocking @(posedge clk); endclocking
   default disable iff (!arst_n);

   a_read_wait: assert property (take && !hwrite |=> !hreadyout ##1 hreadyout)
      else $error("read wait state wrong");
   a_write_nowait: assert property (take && hwrite |=> hreadyout)
      else $error("write stalled");
   a_asi_pair: assert property (send |=> asi_valid ##1 !asi_valid)
      else $error("sample pair not one pulse");
   a_round_low: assert property (send && wl == WL_16
      |=> asi_left[15:0] == 16'h0 && asi_right[15:0] == 16'h0)
      else $error("word not rounded to 16 bits");
   a_modclk_pin: assert property (gpio_fn_q == GPIO_FN_MODCLK
      |=> !gpio_oe_n && gpio_out == $past(st_q[SI_MOD]))
      else $error("modulator clock not on pin");
   a_latch_copy: assert property (
      lat_ev[0] |=> rb_q[0] == $past(live_q[0]))
      else $error("left result not latched");
   a_rb_hold: assert property (!lat_ev[1] |=> $stable(rb_q[1]))
      else $error("readback moved without latch");
   a_dc_range: assert property (
      live_q[0] <= DC_POS && live_q[0] >= DC_NEG)
      else $error("dc result out of 2.22 range");
   a_pd_bypass: assert property (ana_pd_l |-> $past(dmic_l))
      else $error("analog powered down without mic mode");
   a_tap_depth: assert property (
      phase_q[6:5] == 2'h0 |-> tap == 7'(phase_q[4:0]))
      else $error("right delay depth wrong");
   // 5 + 1 * 128 * 0.25 periods for filter A at ratio 128
   a_tap_scale: assert property (
      phase_q == 8'hA5 && filt == FILT_A && adc_oversampling_ratio == ADC_OVERSAMPLING_RATIO_128
      |-> tap == 7'h25)
      else $error("scaled right delay depth wrong");

   c_read: cover property (take && !hwrite ##2 hreadyout);
   c_latch: cover property (lat_ev[0] ##1 rb_q[0] != 24'sh0);
   c_mic_pair: cover property (dmic_l && dmic_r && asi_valid);
endmodule

//--- src/adb_pkg.sv
// How it works
// - Filter B reaches 96 kHz at ratio 64
// - Filter C runs ratio 32 for 192 ksps
// - Filter C pass band near 0.11 rate
// - One 32-bit left/right pair per sample
// - Words rounded to interface word length
// - Modulator clock out on gpio or spi
// - Microphone bit from gpio, din or sclk
// - Left on rising, right on falling edge
// - Microphone mode per left, right, both
// - Microphone mode may bypass analog front
// - Phase delay byte at register 85
// - Right and left delays in modulator periods
// - Filter factors 0.25, 0.5 and 1
// - DC mode enables at 102 bits 7:6
// - DC result 24-bit, 2.22 format
// - Left result 104-106, right 107-109
// - Latch field at 103 copies result
// - Averaging length 1 to 20 at 100
// - Bit 5 clear selects averaging
// - Bit 5 set selects first-order IIR
// - Optional averaging clear every 2^R clocks
// - Filter type follows processing block select
package adb_pkg;
   // register indices; byte address is four times the index
   localparam logic [6:0] IDX_GPIO_FN = 7'h33;
   localparam logic [6:0] IDX_SPI_FN = 7'h37;
   localparam logic [6:0] IDX_PHASE = 7'h55;
   localparam logic [6:0] IDX_DC_LEN = 7'h64;
   localparam logic [6:0] IDX_DC_CTL = 7'h66;
   localparam logic [6:0] IDX_DC_LAT = 7'h67;
   localparam logic [6:0] IDX_DCL_H = 7'h68;
   localparam logic [6:0] IDX_DCL_M = 7'h69;
   localparam logic [6:0] IDX_DCL_L = 7'h6A;
   localparam logic [6:0] IDX_DCR_H = 7'h6B;
   localparam logic [6:0] IDX_DCR_M = 7'h6C;
   localparam logic [6:0] IDX_DCR_L = 7'h6D;
   localparam logic [6:0] IDX_CFG = 7'h20;
   localparam logic [6:0] IDX_STAT = 7'h21;
   localparam int IDX_LSB = 2;
   localparam int IDX_MSB = 8;
   // field positions
   localparam int GPIO_FN_LSB = 2;
   localparam int SPI_FN_LSB = 1;
   localparam logic [3:0] GPIO_FN_MODCLK = 4'hA;
   localparam logic [3:0] SPI_FN_MODCLK = 4'h6;
   localparam int DC_EN_L = 7;
   localparam int DC_EN_R = 6;
   localparam int DC_METH = 5;
   localparam int LAT_L = 7;
   localparam int LAT_R = 6;
   localparam int PRST_EN = 5;
   localparam int CFG_PRB_LSB = 0;
   localparam int CFG_ADC_OVERSAMPLING_RATIO_LSB = 8;
   localparam int CFG_DMIC_L = 16;
   localparam int CFG_DMIC_R = 17;
   localparam int CFG_DSEL_LSB = 18;
   localparam int CFG_BYP_L = 20;
   localparam int CFG_BYP_R = 21;
   localparam int CFG_WL_LSB = 24;
   localparam logic [31:0] CFG_RST = 32'h0000_8001;
   localparam int RES_HI = 16;
   localparam int RES_MID = 8;
   // input selection and processing
   localparam logic [1:0] DSEL_DIN = 2'h1;
   localparam logic [1:0] DSEL_SCLK = 2'h2;
   localparam logic [4:0] PRB_B_FIRST = 5'h07;
   localparam logic [4:0] PRB_C_FIRST = 5'h0D;
   localparam logic [7:0] ADC_OVERSAMPLING_RATIO_32 = 8'h20;
   localparam logic [7:0] ADC_OVERSAMPLING_RATIO_64 = 8'h40;
   localparam logic [7:0] ADC_OVERSAMPLING_RATIO_128 = 8'h80;
   localparam logic [4:0] WORD_TOP = 5'h1E;
   localparam logic [1:0] WL_16 = 2'h0;
   localparam logic [1:0] WL_20 = 2'h1;
   localparam logic [1:0] WL_24 = 2'h2;
   localparam logic [4:0] DROP_16 = 5'h10;
   localparam logic [4:0] DROP_20 = 5'h0C;
   localparam logic [4:0] DROP_24 = 5'h08;
   localparam logic [6:0] DLY_LAST = 7'h7F;
   localparam logic [4:0] DC_LEN_MIN = 5'h01;
   localparam logic [4:0] DC_LEN_MAX = 5'h14;
   localparam logic [4:0] DC_FRAC = 5'h16;
   localparam logic signed [23:0] DC_POS = 24'sh40_0000;
   localparam logic signed [23:0] DC_NEG = 24'shC0_0000;
   // synchroniser lanes
   localparam int NSYNC = 6;
   localparam int SI_MOD = 0;
   localparam int SI_GPIO = 1;
   localparam int SI_DIN = 2;
   localparam int SI_SCLK = 3;
   localparam int SI_ANL = 4;
   localparam int SI_ANR = 5;
   typedef enum logic [1:0] {FILT_A, FILT_B, FILT_C} adb_filt_type;
endpackage

//--- tb/adb_mic_model.sv
module adb_mic_model (
   input wire logic mod_clk,
   input wire logic left_bit,
   input wire logic right_bit,
   output logic mic_data
);
   timeunit 1ns;
   timeprecision 1ps;
   initial mic_data = 1'b0;
   // left bit is held up to the rising edge, right up to the falling
   always @(negedge mod_clk) begin
      mic_data <= left_bit;
   end
   always @(posedge mod_clk) begin
      mic_data <= right_bit;
   end
endmodule

//--- tb/adb_top_bench.sv
module adb_top_bench;
   timeunit 1ns;
   timeprecision 1ps;
   import adb_pkg::*;
   logic clk = 1'b0, mod_clk = 1'b0, arst_n = 1'b0, hsel = 1'b0;
   logic hwrite = 1'b0, ana_bit_l = 1'b0, ana_bit_r = 1'b0;
   logic mic_l = 1'b0, mic_r = 1'b0;
   logic [1:0] htrans = 2'h0, dsel = 2'h0;
   logic [2:0] hsize = 3'h2;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd;
   logic hreadyout, hresp, gpio_out, gpio_oe_n, spi_miso_out, spi_miso_oe_n;
   logic asi_valid, ana_pd_l, ana_pd_r, mic_data;
   logic [31:0] hrdata, asi_left, asi_right;
   wire logic gpio_in, din_in, sclk_in;
   wire logic mic_n = ~mic_data;
   int err_total = 0, checks = 0;

   // unselected pads carry the inverse so a wrong select shows
   assign gpio_in = !gpio_oe_n ? gpio_out : dsel == 2'h0 ? mic_data : mic_n;
   assign din_in = dsel == DSEL_DIN ? mic_data : mic_n;
   assign sclk_in = dsel == DSEL_SCLK ? mic_data : mic_n;

   adb_top i_adb_top (.clk(clk), .arst_n(arst_n), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
      .hrdata(hrdata), .hresp(hresp), .mod_clk_in(mod_clk),
      .ana_bit_l(ana_bit_l), .ana_bit_r(ana_bit_r), .gpio_in(gpio_in),
      .din_in(din_in), .sclk_in(sclk_in), .gpio_out(gpio_out),
      .gpio_oe_n(gpio_oe_n), .spi_miso_out(spi_miso_out),
      .spi_miso_oe_n(spi_miso_oe_n), .asi_left(asi_left),
      .asi_right(asi_right), .asi_valid(asi_valid), .ana_pd_l(ana_pd_l),
      .ana_pd_r(ana_pd_r));
   adb_mic_model i_adb_mic_model (.mod_clk(mod_clk), .left_bit(mic_l),
      .right_bit(mic_r), .mic_data(mic_data));

   always #5 clk = ~clk;
   always #40 mod_clk = ~mod_clk;

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp,
      input string m);
      checks++;
      if (seen !== exp) begin
         err_total++;
         $display("BAD %0t %s seen %h exp %h", $time, m, seen, exp);
      end
   endtask

   task automatic summarize;
      $display("mismatches %0d comparisons %0d", err_total, checks);
      if (err_total == 0 && checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   function automatic logic [31:0] ra(input logic [6:0] i);
      return {23'h0, i, 2'h0};
   endfunction

   // front-end bypass always follows the microphone enables here
   function automatic logic [31:0] cfgw(input logic [4:0] processing_block_select,
      input logic [7:0] adc_oversampling_ratio, input logic [1:0] mic, input logic [1:0] ds,
      input logic [1:0] wl);
      return {6'h0, wl, 2'h0, mic, ds, mic, adc_oversampling_ratio, 3'h0, processing_block_select};
   endfunction

   // only the watchdog ends a wait that never sees ready
   task automatic wait_rdy;
      do begin
         @(posedge clk);
      end while (hreadyout !== 1'b1);
   endtask

   task automatic wait_smp(output int n);
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (asi_valid !== 1'b1);
   endtask

   task automatic ahb(input logic w, input logic [31:0] a,
      input logic [31:0] d);
      hsel <= 1'b1;
      htrans <= 2'b10;
      haddr <= a;
      hwrite <= w;
      wait_rdy();
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      wait_rdy();
      rd = hrdata;
   endtask

   task automatic wr(input logic [6:0] i, input logic [31:0] d);
      ahb(1'b1, ra(i), d);
   endtask

   task automatic rdc(input logic [6:0] i, input logic [31:0] e,
      input string m);
      ahb(1'b0, ra(i), 32'h0);
      chk(rd, e, m);
   endtask

   task automatic t_regs;
      rdc(IDX_CFG, CFG_RST, "cfg reset");
      chk(hresp, 1'b0, "response");
      wr(IDX_PHASE, 32'hFFFF_FFA5);
      rdc(IDX_PHASE, 32'h0000_00A5, "phase");
      ahb(1'b1, 32'h0000_0200 | ra(IDX_PHASE), 32'h0000_005A);
      rdc(IDX_PHASE, 32'h0000_00A5, "alias write");
      ahb(1'b0, 32'h0000_0200 | ra(IDX_PHASE), 32'h0);
      chk(rd, 32'h0, "unmapped read");
      wr(IDX_PHASE, 32'h0);
   endtask

   task automatic t_pins;
      int t;
      logic p;
      wr(IDX_GPIO_FN, 32'(GPIO_FN_MODCLK) << GPIO_FN_LSB);
      wr(IDX_SPI_FN, 32'(SPI_FN_MODCLK) << SPI_FN_LSB);
      repeat (8) @(posedge clk);
      chk({gpio_oe_n, spi_miso_oe_n}, 2'b00, "pins driven");
      t = 0;
      p = gpio_out;
      // 80 clocks hold ten modulator periods, twenty edges
      repeat (80) begin
         @(posedge clk);
         t += (gpio_out !== p) + 100 * (spi_miso_out !== gpio_out);
         p = gpio_out;
      end
      chk(t, 20, "clock out edges");
      wr(IDX_GPIO_FN, 32'h0);
      wr(IDX_SPI_FN, 32'h0);
      repeat (8) @(posedge clk);
      chk({gpio_oe_n, spi_miso_oe_n}, 2'b11, "pins released");
   endtask

   task automatic t_rate(input logic [4:0] processing_block_select, input logic [7:0] adc_oversampling_ratio,
      input logic [31:0] st);
      int n;
      wr(IDX_CFG, cfgw(processing_block_select, adc_oversampling_ratio, 2'b00, DSEL_DIN, 2'h3));
      rdc(IDX_STAT, st, "filter status");
      repeat (3) wait_smp(n);
      chk(n, 32'(adc_oversampling_ratio) * 8, "sample period");
   endtask

   task automatic t_mic(input logic [1:0] m, input logic [1:0] ds,
      input logic [1:0] wl, input logic [3:0] bits);
      int n;
      {mic_l, mic_r, ana_bit_l, ana_bit_r} <= bits;
      dsel <= ds;
      wr(IDX_CFG, cfgw(5'h01, ADC_OVERSAMPLING_RATIO_32, m, ds, wl));
      repeat (3) wait_smp(n);
      chk(asi_left, 32'h4000_0000, "left word");
      chk(asi_right, 32'hC000_0000, "right word");
      chk({ana_pd_r, ana_pd_l}, m, "front end off");
   endtask

   task automatic t_dc;
      int n;
      logic [7:0] b [6];
      b = '{8'h40, 8'h00, 8'h00, 8'hC0, 8'h00, 8'h00};
      {mic_l, mic_r, ana_bit_l, ana_bit_r} <= 4'b1001;
      wr(IDX_CFG, cfgw(5'h01, ADC_OVERSAMPLING_RATIO_32, 2'b11, DSEL_DIN, 2'h3));
      wr(IDX_DC_LEN, 32'(DC_LEN_MIN));
      wr(IDX_DC_CTL, 32'h0000_00C0);
      repeat (2) wait_smp(n);
      wr(IDX_DC_LAT, 32'h0000_00C0);
      for (int i = 0; i < 6; i++) begin
         rdc(IDX_DCL_H + 7'(i), {24'h0, b[i]}, "dc result");
      end
      wr(IDX_DC_LAT, 32'h0);
      mic_l <= 1'b0;
      repeat (2) wait_smp(n);
      rdc(IDX_DCL_H, 32'h0000_0040, "held result");
      wr(IDX_DC_LAT, 32'h0000_00C0);
      rdc(IDX_DCL_H, 32'h0000_00C0, "relatched");
      wr(IDX_DC_LAT, 32'h0);
      wr(IDX_DC_CTL, 32'h0000_00E0);
      mic_l <= 1'b1;
      repeat (3) wait_smp(n);
      wr(IDX_DC_LAT, 32'h0000_00C0);
      ahb(1'b0, ra(IDX_DCL_H), 32'h0);
      chk(rd[7], 1'b0, "iir sign");
      wr(IDX_DC_LAT, 32'h0);
   endtask

   initial begin
      #500_000;
      err_total++;
      summarize();
   end

   initial begin
      repeat (4) @(posedge clk);
      arst_n <= 1'b1;
      t_regs();
      t_pins();
      t_rate(PRB_B_FIRST, ADC_OVERSAMPLING_RATIO_64, 32'h5);
      t_rate(5'h0C, ADC_OVERSAMPLING_RATIO_64, 32'h5);
      t_rate(PRB_C_FIRST, ADC_OVERSAMPLING_RATIO_32, 32'h6);
      t_rate(PRB_C_FIRST, ADC_OVERSAMPLING_RATIO_64, 32'h2);
      t_mic(2'b11, 2'h0, WL_16, 4'b1001);
      t_mic(2'b11, DSEL_DIN, 2'h3, 4'b1001);
      t_mic(2'b11, DSEL_SCLK, 2'h3, 4'b1001);
      t_mic(2'b01, DSEL_DIN, 2'h3, 4'b1100);
      t_mic(2'b10, DSEL_DIN, 2'h3, 4'b0011);
      t_dc();
      summarize();
   end
endmodule
